// file: mpf_map.vh
// Register map and timing constants for the pause flow-control and tag-detect block.
// Functional notes
// - With pass bit set, a valid pause frame sets the packet filter status bit.
// - With pass bit clear, pause frames leave the packet filter status bit cleared.
// - Pause frames are decoded and obeyed only in full duplex with enable set.
// - Every received frame's data is forwarded, whatever its errors or filter result.
// - Promiscuous mode overrides the pass bit in status; an address match does not.
// - Valid pause holds the transmitter off for pause time times slot time.
// - With the enable bit clear no control frame is decoded and nothing pauses.
// - In half duplex the enable bit switches the backpressure function.
// - Busy flag is high while a pause frame is sent or backpressure applied.
// - Busy flag returns to zero once the pause frame has been sent.
// - First tag identifier is compared with received bytes thirteen and fourteen.
// - Second tag identifier is compared with received bytes thirteen and fourteen.
// - A tagged frame may be 1522 bytes long instead of 1518.
// - Upper half pause time field goes into each generated pause frame.
// - No pause frame and no backpressure while the transmitter is disabled.
`ifndef MPF_MAP_VH
`define MPF_MAP_VH
`define MPF_ADDR_W         4
`define MPF_OFS_PAUSE_CTL  4'h8
`define MPF_OFS_TAG_ONE    4'h9
`define MPF_OFS_TAG_TWO    4'hA
`define MPF_RST_PAUSE_CTL  32'h00000000
`define MPF_RST_TAG        16'h0000
`define MPF_BIT_BUSY       0
`define MPF_BIT_ENABLE     1
`define MPF_BIT_PASS       2
`define MPF_PT_HI          31
`define MPF_PT_LO          16
`define MPF_CLK_NS         10
`define MPF_SLOT_BITS      512
`define MPF_BIT_NS_100     10
`define MPF_BIT_NS_10      100
`define MPF_MAX_LEN        11'h5EE
`define MPF_MAX_LEN_TAG    11'h5F2
`define MPF_POS_TYPE_HI    11'h00C
`define MPF_POS_TYPE_LO    11'h00D
`define MPF_POS_OP_HI      11'h00E
`define MPF_POS_OP_LO      11'h00F
`define MPF_POS_PT_HI      11'h010
`define MPF_POS_PT_LO      11'h011
`define MPF_CTL_TYPE       16'h8808
`define MPF_PAUSE_OPCODE   16'h0001
`define MPF_BUF_W          11
`endif

// file: mpf_skid.v
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module mpf_skid #(
  parameter W = 11
) (
  clk_sys,
  rst_b,
  in_data,
  in_valid,
  in_ready,
  out_data,
  out_valid,
  out_ready
);
  input  wire         clk_sys;
  input  wire         rst_b;
  input  wire [W-1:0] in_data;
  input  wire         in_valid;
  output wire         in_ready;
  output wire [W-1:0] out_data;
  output wire         out_valid;
  input  wire         out_ready;

  reg [W-1:0] mem_q [0:1];
  reg         wr_ptr_q;
  reg         rd_ptr_q;
  reg [1:0]   count_q;
  wire        push;
  wire        pop;

  assign in_ready  = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data;
        wr_ptr_q        <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push & ~pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop & ~push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule

// file: mpf_flow_tag.v
// Pause flow control, backpressure and tag detection for a 10/100 MAC receive path.
`timescale 1ns/1ps
`include "mpf_map.vh"
module mpf_flow_tag #(
  parameter SLOT_CYC_10 = `MPF_SLOT_BITS * `MPF_BIT_NS_10 / `MPF_CLK_NS
) (
  clk_sys,
  rst_b,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  full_duplex,
  speed_100,
  tx_enable,
  promisc_mode,
  addr_match,
  bp_request,
  pause_trigger,
  rx_in_data,
  rx_in_sof,
  rx_in_eof,
  rx_in_err,
  rx_in_valid,
  rx_in_ready,
  rx_out_data,
  rx_out_sof,
  rx_out_eof,
  rx_out_err,
  rx_out_valid,
  rx_out_ready,
  rx_stat_valid,
  rx_stat_filter,
  rx_stat_tag_one,
  rx_stat_tag_two,
  rx_stat_too_long,
  rx_stat_pause,
  tx_pause_req,
  tx_pause_time,
  tx_pause_done,
  tx_hold,
  backpressure
);
  input  wire                  clk_sys;
  input  wire                  rst_b;
  input  wire [`MPF_ADDR_W-1:0] reg_addr;
  input  wire [31:0]           reg_wdata;
  input  wire                  reg_wr;
  input  wire                  reg_rd;
  output reg  [31:0]           reg_rdata;
  input  wire                  full_duplex;
  input  wire                  speed_100;
  input  wire                  tx_enable;
  input  wire                  promisc_mode;
  input  wire                  addr_match;
  input  wire                  bp_request;
  input  wire                  pause_trigger;
  input  wire [7:0]            rx_in_data;
  input  wire                  rx_in_sof;
  input  wire                  rx_in_eof;
  input  wire                  rx_in_err;
  input  wire                  rx_in_valid;
  output wire                  rx_in_ready;
  output wire [7:0]            rx_out_data;
  output wire                  rx_out_sof;
  output wire                  rx_out_eof;
  output wire                  rx_out_err;
  output wire                  rx_out_valid;
  input  wire                  rx_out_ready;
  output reg                   rx_stat_valid;
  output reg                   rx_stat_filter;
  output reg                   rx_stat_tag_one;
  output reg                   rx_stat_tag_two;
  output reg                   rx_stat_too_long;
  output reg                   rx_stat_pause;
  output reg                   tx_pause_req;
  output wire [15:0]           tx_pause_time;
  input  wire                  tx_pause_done;
  output wire                  tx_hold;
  output reg                   backpressure;

  localparam integer SLOT_100_I  = `MPF_SLOT_BITS * `MPF_BIT_NS_100 / `MPF_CLK_NS;
  localparam [12:0] SLOT_CYC_100 = SLOT_100_I[12:0];
  localparam [12:0] SLOT_10_W    = SLOT_CYC_10[12:0];
  localparam [31:0] RST_CTL      = `MPF_RST_PAUSE_CTL;
  localparam [0:0]  ST_IDLE      = 1'b0;
  localparam [0:0]  ST_SEND      = 1'b1;

  // Pause control register fields and the two tag identifiers.
  reg  [15:0] pause_time_field_q;
  reg         pass_pause_frames_bit_q;
  reg         pause_function_enable_bit_q;
  reg  [15:0] first_tag_identifier_q;
  reg  [15:0] second_tag_identifier_q;
  reg         pause_busy_flag;

  // Receive parse state.
  reg  [10:0] byte_cnt_q;
  reg         in_frame_q;
  reg  [15:0] type_q;
  reg  [15:0] opcode_q;
  reg  [15:0] rx_pause_val_q;
  reg         da_ok_q;

  // Pause timer and pause frame sender.
  reg  [15:0] quanta_q;
  reg  [12:0] slot_cnt_q;
  reg         tx_state_q;

  wire        beat;
  wire        frame_end;
  wire        pause_active;
  wire [15:0] type_full;
  wire [15:0] op_full;
  wire [15:0] pt_full;
  wire        tag_one_hit;
  wire        tag_two_hit;
  wire        is_pause;
  wire [10:0] len_now;
  wire [10:0] max_len;
  wire [12:0] slot_len;

  // Byte of the reserved multicast address that every pause frame carries.
  function [7:0] pause_da_byte;
    input [10:0] idx;
    begin
      case (idx)
        11'h000: pause_da_byte = 8'h01;
        11'h001: pause_da_byte = 8'h80;
        11'h002: pause_da_byte = 8'hC2;
        11'h003: pause_da_byte = 8'h00;
        11'h004: pause_da_byte = 8'h00;
        default: pause_da_byte = 8'h01;
      endcase
    end
  endfunction

  // Every beat goes into the buffer unfiltered; status reports what was seen.
  mpf_skid #(
    .W (`MPF_BUF_W)
  ) u_skid (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_data   ({rx_in_err, rx_in_eof, rx_in_sof, rx_in_data}),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .out_data  ({rx_out_err, rx_out_eof, rx_out_sof, rx_out_data}),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready)
  );

  assign beat      = rx_in_valid & rx_in_ready;
  assign frame_end = beat & rx_in_eof;
  assign len_now   = rx_in_sof ? 11'h001 : byte_cnt_q + 11'h001;

  // The frame's last byte may itself complete a field, so merge it in here.
  assign type_full = (byte_cnt_q == `MPF_POS_TYPE_LO) ? {type_q[15:8], rx_in_data} : type_q;
  assign op_full   = (byte_cnt_q == `MPF_POS_OP_LO) ? {opcode_q[15:8], rx_in_data} : opcode_q;
  assign pt_full   = (byte_cnt_q == `MPF_POS_PT_LO) ? {rx_pause_val_q[15:8], rx_in_data} : rx_pause_val_q;

  assign tag_one_hit = (len_now > `MPF_POS_TYPE_LO) && (type_full == first_tag_identifier_q);
  assign tag_two_hit = (len_now > `MPF_POS_TYPE_LO) && (type_full == second_tag_identifier_q);
  assign max_len     = (tag_one_hit | tag_two_hit) ? `MPF_MAX_LEN_TAG : `MPF_MAX_LEN;

  // Control frames are recognised only with the function enabled in full duplex.
  assign is_pause = pause_function_enable_bit_q & full_duplex & da_ok_q & ~rx_in_err &
                    (len_now > `MPF_POS_PT_LO) && (type_full == `MPF_CTL_TYPE) &&
                    (op_full == `MPF_PAUSE_OPCODE);

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      byte_cnt_q     <= 11'h000;
      in_frame_q     <= 1'b0;
      type_q         <= 16'h0000;
      opcode_q       <= 16'h0000;
      rx_pause_val_q <= 16'h0000;
      da_ok_q        <= 1'b0;
    end else if (beat) begin
      if (rx_in_sof) begin
        byte_cnt_q <= 11'h001;
        da_ok_q    <= (rx_in_data == pause_da_byte(11'h000));
      end else if (byte_cnt_q != 11'h7FF) begin
        byte_cnt_q <= byte_cnt_q + 11'h001;
        if (byte_cnt_q < 11'h006) begin
          da_ok_q <= da_ok_q & (rx_in_data == pause_da_byte(byte_cnt_q));
        end
      end
      in_frame_q <= ~rx_in_eof;
      if (byte_cnt_q == `MPF_POS_TYPE_HI) begin
        type_q[15:8] <= rx_in_data;
      end
      if (byte_cnt_q == `MPF_POS_TYPE_LO) begin
        type_q[7:0] <= rx_in_data;
      end
      if (byte_cnt_q == `MPF_POS_OP_HI) begin
        opcode_q[15:8] <= rx_in_data;
      end
      if (byte_cnt_q == `MPF_POS_OP_LO) begin
        opcode_q[7:0] <= rx_in_data;
      end
      if (byte_cnt_q == `MPF_POS_PT_HI) begin
        rx_pause_val_q[15:8] <= rx_in_data;
      end
      if (byte_cnt_q == `MPF_POS_PT_LO) begin
        rx_pause_val_q[7:0] <= rx_in_data;
      end
    end
  end

  // Status is presented for one cycle after the frame's last byte is taken.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_stat_valid    <= 1'b0;
      rx_stat_filter   <= 1'b0;
      rx_stat_tag_one  <= 1'b0;
      rx_stat_tag_two  <= 1'b0;
      rx_stat_too_long <= 1'b0;
      rx_stat_pause    <= 1'b0;
    end else begin
      rx_stat_valid <= frame_end;
      if (frame_end) begin
        rx_stat_tag_one  <= tag_one_hit;
        rx_stat_tag_two  <= tag_two_hit;
        rx_stat_too_long <= len_now > max_len;
        rx_stat_pause    <= is_pause;
        if (promisc_mode) begin
          rx_stat_filter <= 1'b1;
        end else if (is_pause) begin
          rx_stat_filter <= pass_pause_frames_bit_q;
        end else begin
          rx_stat_filter <= addr_match;
        end
      end
    end
  end

  // Pause interval: quanta of 512 bit times, length picked by link speed.
  assign slot_len     = speed_100 ? SLOT_CYC_100 : SLOT_10_W;
  assign pause_active = (quanta_q != 16'h0000);
  assign tx_hold      = pause_active;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      quanta_q   <= 16'h0000;
      slot_cnt_q <= 13'h0000;
    end else if (frame_end && is_pause) begin
      quanta_q   <= pt_full;
      slot_cnt_q <= slot_len - 13'h0001;
    end else if (!pause_function_enable_bit_q) begin
      quanta_q   <= 16'h0000;
      slot_cnt_q <= 13'h0000;
    end else if (pause_active) begin
      if (slot_cnt_q == 13'h0000) begin
        quanta_q   <= quanta_q - 16'h0001;
        slot_cnt_q <= slot_len - 13'h0001;
      end else begin
        slot_cnt_q <= slot_cnt_q - 13'h0001;
      end
    end
  end

  // Pause frame sender: a request holds until the transmitter reports it sent.
  assign tx_pause_time = pause_time_field_q;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_q   <= ST_IDLE;
      tx_pause_req <= 1'b0;
    end else begin
      case (tx_state_q)
        ST_IDLE: begin
          if (pause_trigger && full_duplex && tx_enable) begin
            tx_state_q   <= ST_SEND;
            tx_pause_req <= 1'b1;
          end
        end
        ST_SEND: begin
          if (tx_pause_done) begin
            tx_state_q   <= ST_IDLE;
            tx_pause_req <= 1'b0;
          end
        end
        default: begin
          tx_state_q   <= ST_IDLE;
          tx_pause_req <= 1'b0;
        end
      endcase
    end
  end

  // Half-duplex backpressure, gated by the enable bit and the transmitter.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      backpressure <= 1'b0;
    end else begin
      backpressure <= ~full_duplex & pause_function_enable_bit_q & tx_enable & bp_request;
    end
  end

  always @* begin
    pause_busy_flag = tx_pause_req | backpressure;
  end

  // Register writes. The busy bit is status only; a written value is ignored.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pause_time_field_q          <= RST_CTL[`MPF_PT_HI:`MPF_PT_LO];
      pass_pause_frames_bit_q     <= 1'b0;
      pause_function_enable_bit_q <= 1'b0;
      first_tag_identifier_q      <= `MPF_RST_TAG;
      second_tag_identifier_q     <= `MPF_RST_TAG;
    end else if (reg_wr) begin
      case (reg_addr)
        `MPF_OFS_PAUSE_CTL: begin
          pause_time_field_q          <= reg_wdata[`MPF_PT_HI:`MPF_PT_LO];
          pass_pause_frames_bit_q     <= reg_wdata[`MPF_BIT_PASS];
          pause_function_enable_bit_q <= reg_wdata[`MPF_BIT_ENABLE];
        end
        `MPF_OFS_TAG_ONE: begin
          first_tag_identifier_q <= reg_wdata[15:0];
        end
        `MPF_OFS_TAG_TWO: begin
          second_tag_identifier_q <= reg_wdata[15:0];
        end
        default: begin
          first_tag_identifier_q <= first_tag_identifier_q;
        end
      endcase
    end
  end

  // Read data stands in the cycle after the read strobe; unmapped reads give zero.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `MPF_OFS_PAUSE_CTL: reg_rdata <= {pause_time_field_q, 13'h0000, pass_pause_frames_bit_q,
                                          pause_function_enable_bit_q, pause_busy_flag};
        `MPF_OFS_TAG_ONE:   reg_rdata <= {16'h0000, first_tag_identifier_q};
        `MPF_OFS_TAG_TWO:   reg_rdata <= {16'h0000, second_tag_identifier_q};
        default:            reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule

// file: mpf_tx_model.sv
// Transmitter stand-in that sends a requested pause frame after a delay.
`timescale 1ns/1ps
module mpf_tx_model #(
  parameter DLY = 20
) (
  input  wire clk_sys,
  input  wire rst_b,
  input  wire tx_pause_req,
  output reg  tx_pause_done
);
  integer n_q;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      n_q <= 0;
      tx_pause_done <= 1'b0;
    end else begin
      tx_pause_done <= tx_pause_req && n_q == DLY - 1;
      n_q <= (tx_pause_req && !tx_pause_done) ? n_q + 1 : 0;
    end
  end
endmodule

// file: mpf_flow_tag_sva.sv
// Assertion checker for the pause flow-control and tag-detect block.
`timescale 1ns/1ps
module mpf_flow_tag_sva (
  input wire clk_sys,
  input wire rst_b,
  input wire full_duplex,
  input wire tx_enable,
  input wire promisc_mode,
  input wire bp_request,
  input wire pause_trigger,
  input wire rx_in_valid,
  input wire rx_in_ready,
  input wire rx_in_eof,
  input wire rx_stat_valid,
  input wire rx_stat_filter,
  input wire rx_stat_pause,
  input wire tx_pause_req,
  input wire tx_pause_done,
  input wire tx_hold,
  input wire backpressure
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_done_ends_req: assert property (tx_pause_req && tx_pause_done |=> !tx_pause_req)
    else $error("pause request held after done");
  a_req_fall_done: assert property ($fell(tx_pause_req) |-> $past(tx_pause_done))
    else $error("pause request dropped early");
  a_req_needs_tx: assert property ($rose(tx_pause_req) |-> $past(pause_trigger && full_duplex && tx_enable))
    else $error("pause request without cause");
  a_bp_cause: assert property (backpressure |-> $past(!full_duplex && tx_enable && bp_request))
    else $error("backpressure without cause");
  a_stat_cause: assert property (rx_stat_valid |-> $past(rx_in_valid && rx_in_ready && rx_in_eof))
    else $error("status without frame end");
  a_promisc_flt: assert property (rx_stat_valid && $past(promisc_mode) |-> rx_stat_filter)
    else $error("filter bit clear in promiscuous mode");
  a_pause_fd: assert property (rx_stat_valid && rx_stat_pause |-> $past(full_duplex))
    else $error("pause decoded in half duplex");
  a_hold_start: assert property ($rose(tx_hold) |-> rx_stat_valid && rx_stat_pause)
    else $error("hold without pause frame");
endmodule
bind mpf_flow_tag mpf_flow_tag_sva chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .full_duplex(full_duplex), .tx_enable(tx_enable), .promisc_mode(promisc_mode),
  .bp_request(bp_request), .pause_trigger(pause_trigger), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
  .rx_in_eof(rx_in_eof), .rx_stat_valid(rx_stat_valid), .rx_stat_filter(rx_stat_filter),
  .rx_stat_pause(rx_stat_pause), .tx_pause_req(tx_pause_req), .tx_pause_done(tx_pause_done), .tx_hold(tx_hold),
  .backpressure(backpressure)
);

// file: mpf_flow_tag_test.sv
// Self-checking bench for the pause flow-control and tag-detect block.
`timescale 1ns/1ps
`include "mpf_map.vh"
module mpf_flow_tag_test;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        full_duplex = 1'b1;
  logic        speed_100 = 1'b1;
  logic        tx_enable = 1'b1;
  logic        promisc_mode = 1'b0;
  logic        addr_match = 1'b0;
  logic        bp_request = 1'b0;
  logic        pause_trigger = 1'b0;
  logic [7:0]  rx_in_data = 8'h0;
  logic        rx_in_sof = 1'b0;
  logic        rx_in_eof = 1'b0;
  logic        rx_in_err = 1'b0;
  logic        rx_in_valid = 1'b0;
  logic        rx_out_ready = 1'b1;
  logic        rd_seen = 1'b0;
  wire  [31:0] reg_rdata;
  wire  [7:0]  rx_out_data;
  wire  [15:0] tx_pause_time;
  wire         rx_in_ready, rx_out_valid, rx_stat_valid, rx_stat_filter, rx_stat_tag_one;
  wire         rx_stat_tag_two, rx_stat_too_long, rx_stat_pause, tx_pause_req, tx_pause_done;
  wire         tx_hold, backpressure, rx_out_sof, rx_out_eof, rx_out_err;
  logic [31:0] rq[$];
  logic [10:0] bq[$];
  logic [15:0] tg1 = 16'h0000;
  logic [15:0] tg2 = 16'h0000;
  logic [4:0]  sq[$];
  logic [31:0] ctl_m = 32'h0;
  logic [31:0] seed = 32'h8E4B;
  logic [31:0] sk = 32'h8E4B;
  integer      fails = 0;
  integer      checked = 0;
  integer      hold_n = 0;
  integer      hold_last = 0;
  localparam [3:0] CTL = `MPF_OFS_PAUSE_CTL;
  localparam [15:0] PT = `MPF_CTL_TYPE;

  mpf_flow_tag #(.SLOT_CYC_10(8)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .full_duplex(full_duplex), .speed_100(speed_100),
    .tx_enable(tx_enable), .promisc_mode(promisc_mode), .addr_match(addr_match), .bp_request(bp_request),
    .pause_trigger(pause_trigger), .rx_in_data(rx_in_data), .rx_in_sof(rx_in_sof), .rx_in_eof(rx_in_eof),
    .rx_in_err(rx_in_err), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_out_data(rx_out_data),
    .rx_out_sof(rx_out_sof), .rx_out_eof(rx_out_eof), .rx_out_err(rx_out_err), .rx_out_valid(rx_out_valid),
    .rx_out_ready(rx_out_ready), .rx_stat_valid(rx_stat_valid), .rx_stat_filter(rx_stat_filter),
    .rx_stat_tag_one(rx_stat_tag_one), .rx_stat_tag_two(rx_stat_tag_two), .rx_stat_too_long(rx_stat_too_long),
    .rx_stat_pause(rx_stat_pause), .tx_pause_req(tx_pause_req), .tx_pause_time(tx_pause_time),
    .tx_pause_done(tx_pause_done), .tx_hold(tx_hold), .backpressure(backpressure)
  );
  mpf_tx_model #(.DLY(20)) tx (
    .clk_sys(clk_sys), .rst_b(rst_b), .tx_pause_req(tx_pause_req), .tx_pause_done(tx_pause_done)
  );

  always #5 clk_sys = ~clk_sys;

  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Byte k of a frame, counted from 1; the pause address goes to the control group only when pd is set.
  function logic [7:0] fb(input integer k, input logic [15:0] ty, pt, input logic pd, input logic [7:0] r);
    case (k)
      1: fb = pd ? 8'h01 : 8'h03;
      2: fb = 8'h80;
      3: fb = 8'hC2;
      4, 5, 15: fb = 8'h00;
      6, 16: fb = 8'h01;
      13: fb = ty[15:8];
      14: fb = ty[7:0];
      17: fb = pt[15:8];
      18: fb = pt[7:0];
      default: fb = r;
    endcase
  endfunction

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked = checked + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask

  task finish_test;
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    if (a == CTL) ctl_m = d;
    if (a == `MPF_OFS_TAG_ONE) tg1 = d[15:0];
    if (a == `MPF_OFS_TAG_TWO) tg2 = d[15:0];
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  task send(input logic [15:0] ty, pt, input integer len, input logic pd, am, er);
    logic [7:0] b;
    logic       pz;
    logic       t1;
    logic       t2;
    integer     k;
    @(posedge clk_sys);
    pz = ctl_m[1] && full_duplex && ty == PT && pd && !er;
    t1 = ty == tg1;
    t2 = ty == tg2;
    sq.push_back({promisc_mode | (pz ? ctl_m[2] : am), t1, t2, len > ((t1 | t2) ? 1522 : 1518), pz});
    for (k = 1; k <= len; k++) begin
      seed = lfsr(seed);
      b = fb(k, ty, pt, pd, seed[7:0]);
      bq.push_back({er, k == len, k == 1, b});
      rx_in_data <= b;
      rx_in_sof <= k == 1;
      rx_in_eof <= k == len;
      rx_in_err <= er;
      addr_match <= am;
      rx_in_valid <= 1'b1;
      do @(posedge clk_sys); while (!rx_in_ready);
    end
    rx_in_valid <= 1'b0;
  endtask

  task hold(input integer e);
    repeat (e + 20) @(posedge clk_sys);
    chk("hold", hold_last >= e - 1 && hold_last <= e + 1, 1);
  endtask

  task trig;
    @(posedge clk_sys);
    pause_trigger <= 1'b1;
    @(posedge clk_sys);
    pause_trigger <= 1'b0;
  endtask

  always @(posedge clk_sys) begin
    if (rd_seen) chk("rdata", reg_rdata, rq.pop_front());
    rd_seen <= reg_rd;
    if (rx_out_valid && rx_out_ready) chk("rxbyte", {rx_out_err, rx_out_eof, rx_out_sof, rx_out_data},
      bq.pop_front());
    if (rx_stat_valid) chk("status", {rx_stat_filter, rx_stat_tag_one, rx_stat_tag_two, rx_stat_too_long,
      rx_stat_pause}, sq.pop_front());
    sk <= lfsr(sk);
    rx_out_ready <= sk[3] | sk[7];
    if (tx_hold) hold_n <= hold_n + 1;
    else if (hold_n != 0) begin
      hold_last <= hold_n;
      hold_n <= 0;
    end
  end

  initial begin
    #400000;
    fails = fails + 1;
    finish_test;
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(CTL, 0);
    rd(`MPF_OFS_TAG_ONE, 0);
    rd(`MPF_OFS_TAG_TWO, 0);
    wr(4'hB, 32'hFFFFFFFF);
    rd(4'hB, 0);
    wr(`MPF_OFS_TAG_ONE, 32'h00008100);
    send(16'h8100, 0, 1520, 0, 0, 0);
    wr(`MPF_OFS_TAG_TWO, 32'h00008100);
    rd(`MPF_OFS_TAG_TWO, 32'h00008100);
    wr(CTL, 32'h00020006);
    rd(CTL, 32'h00020006);
    send(PT, 16'h0002, 64, 1, 0, 0);
    hold(1024);
    wr(CTL, 32'h00020002);
    send(PT, 16'h0000, 64, 1, 0, 0);
    promisc_mode <= 1'b1;
    send(PT, 16'h0000, 64, 1, 0, 0);
    promisc_mode <= 1'b0;
    wr(CTL, 32'h00020004);
    send(PT, 16'h0005, 64, 1, 1, 0);
    wr(CTL, 32'h00020006);
    full_duplex <= 1'b0;
    send(PT, 16'h0005, 64, 1, 1, 0);
    full_duplex <= 1'b1;
    send(PT, 16'h0005, 64, 1, 0, 1);
    repeat (3) @(posedge clk_sys);
    chk("hold_off", tx_hold, 0);
    send(16'h8100, 0, 1522, 0, 1, 0);
    send(16'h8100, 0, 1523, 0, 1, 0);
    send(16'h0800, 0, 1519, 0, 0, 0);
    send(16'h0800, 0, 1518, 0, 0, 0);
    speed_100 <= 1'b0;
    send(PT, 16'h0003, 64, 1, 0, 0);
    hold(24);
    speed_100 <= 1'b1;
    tx_enable <= 1'b0;
    trig;
    repeat (3) @(posedge clk_sys);
    chk("req_off", tx_pause_req, 0);
    tx_enable <= 1'b1;
    rd(CTL, 32'h00020006);
    wr(CTL, 32'h12340006);
    trig;
    repeat (2) @(posedge clk_sys);
    chk("ptime", tx_pause_time, 16'h1234);
    rd(CTL, 32'h12340007);
    repeat (30) @(posedge clk_sys);
    rd(CTL, 32'h12340006);
    full_duplex <= 1'b0;
    bp_request <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("bp_on", backpressure, 1);
    rd(CTL, 32'h12340007);
    tx_enable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("bp_tx", backpressure, 0);
    wr(CTL, 32'h12340004);
    tx_enable <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("bp_en", backpressure, 0);
    repeat (40) @(posedge clk_sys);
    chk("left", rq.size() + bq.size() + sq.size(), 0);
    finish_test;
  end
endmodule
